// ===== src/rel_counter.sv
// One saturating one-byte error counter with clear.
`timescale 1ns/100ps
module rel_counter #(
    parameter int WIDTH = 8
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic inc,
    input wire logic clr,
    output logic [WIDTH-1:0] count
);
    // A clear and an event in the same cycle leave a count of one, so the
    // event is not lost behind the log snapshot.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
        end else if (clr) begin
            count <= inc ? WIDTH'(1) : '0;
        end else if (inc && count != {WIDTH{1'b1}}) begin
            count <= count + WIDTH'(1);
        end
    end
endmodule // rel_counter

// ===== src/rel_log.sv
// Ring soft-error log: event counters, log write-out and status block.
// Summary of operation
// - Line error counter advances at most once per frame.
// - Line error advances when repeated or copied frame has indicator zero.
// - Line error advances on code violation between start and end delimiter.
// - Line error advances on token code violation or frame check failure.
// - Burst error advances after five transition-free half-bits inside frame.
// - After four transition-free half-bits, transmitter switches to idles.
// - Address/copied set error on zero-bit standby monitor frame after a zero-bit monitor frame.
// - Lost frame advances when own stripped frame's end never returns.
// - Receive congestion advances on own-address match without free buffer.
// - Frame copied error advances on own-address match with nonzero bits.
// - Token error counter is one byte, updated only as active monitor.
// - Token error on nonzero-priority token with monitor pass bit set.
// - Token error on any non-token frame with monitor pass bit set.
// - Token error when no token or frame arrives within ten ms.
// - Token error on forbidden code violation in delimiter/token sequence.
// - DMA bus error counter counts errors below the abort threshold.
// - DMA parity error counter counts errors below the abort threshold.
// - Status block holds command code then completion field.
// - Completion bit zero is one, bits one to fifteen zero.
// - Fourteen-byte log written at host-given 24-bit address.
// - Reading the log clears every counter.
`timescale 1ns/100ps
module rel_log #(
    parameter int TOKEN_WINDOW_CYC = rel_pkg::TOKEN_WINDOW_CYC,
    parameter int DMA_ABORT_LIMIT = 8
) (
    input wire logic core_clk,
    input wire logic rst_n,
    // Frame parser pulses, station mode levels and DMA error inputs.
    input wire logic frame_start_delimiter,
    input wire logic frame_end_delimiter,
    input wire logic frame_is_token,
    input wire logic frame_repeat_or_copy,
    input wire logic error_detected_indicator,
    input wire logic code_violation,
    input wire logic token_code_violation,
    input wire logic fcs_error,
    input wire logic half_bit_no_transition,
    input wire logic half_bit_transition,
    input wire logic monitor_pass_bit,
    input wire logic [2:0] token_priority,
    input wire logic active_monitor_present_frame,
    input wire logic standby_monitor_present_frame,
    input wire logic [1:0] address_recognized_copied_bits,
    input wire logic own_address_match,
    input wire logic rx_buffer_free,
    input wire logic repeat_mode,
    input wire logic strip_mode,
    input wire logic own_frame_lost,
    input wire logic active_monitor,
    input wire logic dma_bus_error,
    input wire logic dma_parity_error,
    input wire logic dma_error_clear,
    // Host command from the system command block.
    input wire logic cmd_valid,
    input wire logic [15:0] cmd_code,
    input wire logic [23:0] cmd_address,
    // Outbound word writes toward the DMA engine, command status and idle forcing.
    input wire logic wr_ready,
    output logic wr_valid,
    output logic [23:0] wr_address,
    output logic [15:0] wr_data,
    output logic cmd_busy,
    output logic cmd_done,
    output logic tx_force_idle
);
    // ==================================================================
    // Frame tracking
    // ==================================================================
    logic in_frame;
    logic line_seen;
    logic [2:0] quiet_hb;
    logic arfc_armed;
    logic [31:0] watch_cnt;
    logic [7:0] dma_bus_run;
    logic [7:0] dma_par_run;
    logic clr_all;
    logic [rel_pkg::N_CNT-1:0] inc;
    logic [7:0] cnt [rel_pkg::N_CNT];
    rel_pkg::rel_state_type state;
    logic [2:0] word_ix;
    logic [23:0] base_addr;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            in_frame <= 1'b0;
        end else if (frame_start_delimiter) begin
            in_frame <= 1'b1;
        end else if (frame_end_delimiter) begin
            in_frame <= 1'b0;
        end
    end

    // Once a frame has been charged, further faults in it are ignored.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            line_seen <= 1'b0;
        end else if (frame_start_delimiter) begin
            line_seen <= 1'b0;
        end else if (inc[rel_pkg::IX_LINE]) begin
            line_seen <= 1'b1;
        end
    end

    logic line_cause;
    assign line_cause = (frame_end_delimiter && frame_repeat_or_copy
                         && !error_detected_indicator)
        || (in_frame && code_violation)
        || (frame_end_delimiter && (token_code_violation
                                    || fcs_error));
    assign inc[rel_pkg::IX_LINE] = line_cause && !line_seen;

    // ==================================================================
    // Burst detection
    // ==================================================================
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            quiet_hb <= 3'h0;
        end else if (half_bit_transition || !in_frame) begin
            quiet_hb <= 3'h0;
        end else if (half_bit_no_transition
                     && quiet_hb != rel_pkg::BURST_ERR_HB) begin
            quiet_hb <= quiet_hb + 3'h1;
        end
    end

    assign inc[rel_pkg::IX_BURST] = in_frame && half_bit_no_transition
        && quiet_hb == rel_pkg::BURST_ERR_HB - 3'h1;

    // Idles go out from four quiet half-bits on so that the station
    // downstream never itself sees a burst of five.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_force_idle <= 1'b0;
        end else begin
            tx_force_idle <= in_frame && !half_bit_transition
                && !frame_end_delimiter
                && (quiet_hb >= rel_pkg::BURST_IDLE_HB
                    || (half_bit_no_transition && quiet_hb
                        == rel_pkg::BURST_IDLE_HB - 3'h1));
        end
    end

    // ==================================================================
    // Monitor frame checks
    // ==================================================================
    logic mon_zero;
    assign mon_zero = (active_monitor_present_frame
                       || standby_monitor_present_frame)
        && address_recognized_copied_bits == 2'b00;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            arfc_armed <= 1'b0;
        end else if (active_monitor_present_frame) begin
            arfc_armed <= mon_zero;
        end else if (mon_zero) begin
            arfc_armed <= 1'b1;
        end
    end

    assign inc[rel_pkg::IX_ARFC] = mon_zero && arfc_armed
        && !active_monitor_present_frame;
    assign inc[rel_pkg::IX_LOST] = strip_mode && own_frame_lost;
    assign inc[rel_pkg::IX_CONG] = repeat_mode && own_address_match
        && !rx_buffer_free;
    assign inc[rel_pkg::IX_COPY] = repeat_mode && own_address_match
        && address_recognized_copied_bits != 2'b00;

    // ==================================================================
    // Active monitor token checks
    // ==================================================================
    logic watch_expired;
    logic ring_seen;
    assign ring_seen = frame_end_delimiter;
    assign watch_expired = watch_cnt == 32'(TOKEN_WINDOW_CYC - 1);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            watch_cnt <= 32'h0;
        end else if (!active_monitor || ring_seen || watch_expired) begin
            watch_cnt <= 32'h0;
        end else begin
            watch_cnt <= watch_cnt + 32'h1;
        end
    end

    assign inc[rel_pkg::IX_TOKEN] = active_monitor && (
        (frame_end_delimiter && frame_is_token && monitor_pass_bit
         && token_priority != 3'h0)
        || (frame_end_delimiter && !frame_is_token
            && monitor_pass_bit)
        || (watch_expired && !ring_seen)
        || (frame_end_delimiter && frame_is_token
            && token_code_violation));

    // ==================================================================
    // DMA error runs below the abort threshold
    // ==================================================================
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            dma_bus_run <= 8'h00;
        end else if (dma_error_clear) begin
            dma_bus_run <= 8'h00;
        end else if (dma_bus_error && dma_bus_run != 8'hFF) begin
            dma_bus_run <= dma_bus_run + 8'h01;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            dma_par_run <= 8'h00;
        end else if (dma_error_clear) begin
            dma_par_run <= 8'h00;
        end else if (dma_parity_error && dma_par_run != 8'hFF) begin
            dma_par_run <= dma_par_run + 8'h01;
        end
    end

    assign inc[rel_pkg::IX_DMABUS] = dma_bus_error
        && 32'(dma_bus_run) < 32'(DMA_ABORT_LIMIT - 1);
    assign inc[rel_pkg::IX_DMAPAR] = dma_parity_error
        && 32'(dma_par_run) < 32'(DMA_ABORT_LIMIT - 1);

    // ==================================================================
    // Counters
    // ==================================================================
    for (genvar i = 0; i < rel_pkg::N_CNT; i++) begin : g_cnt
        rel_counter #(
            .WIDTH(rel_pkg::CNT_W)
        ) u_cnt (
            .core_clk(core_clk),
            .rst_n(rst_n),
            .inc(inc[i]),
            .clr(clr_all),
            .count(cnt[i])
        );
    end

    // ==================================================================
    // Log read command
    // ==================================================================
    // The log is copied to a snapshot at command start so events during
    // the write-out count toward the next read instead of being lost.
    logic [7:0] snap [rel_pkg::N_CNT];
    logic [15:0] log_word;
    logic accept;
    logic wr_fire;
    assign accept = state == rel_pkg::REL_IDLE && cmd_valid
        && cmd_code == rel_pkg::CMD_READ_LOG;
    assign clr_all = accept;
    assign wr_fire = wr_valid && wr_ready;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int k = 0; k < rel_pkg::N_CNT; k++) begin
                snap[k] <= rel_pkg::CNT_RST;
            end
        end else if (accept) begin
            for (int k = 0; k < rel_pkg::N_CNT; k++) begin
                snap[k] <= cnt[k];
            end
        end
    end

    always_comb begin
        case (word_ix)
            3'h0: log_word = {snap[rel_pkg::IX_LINE], rel_pkg::RSVD_BYTE};
            3'h1: log_word = {snap[rel_pkg::IX_BURST],
                              snap[rel_pkg::IX_ARFC]};
            3'h3: log_word = {snap[rel_pkg::IX_LOST],
                              snap[rel_pkg::IX_CONG]};
            3'h4: log_word = {snap[rel_pkg::IX_COPY], rel_pkg::RSVD_BYTE};
            3'h5: log_word = {snap[rel_pkg::IX_TOKEN], rel_pkg::RSVD_BYTE};
            3'h6: log_word = {snap[rel_pkg::IX_DMABUS],
                              snap[rel_pkg::IX_DMAPAR]};
            default: log_word = 16'h0000;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= rel_pkg::REL_IDLE;
            word_ix <= 3'h0;
            base_addr <= 24'h000000;
            wr_valid <= 1'b0;
            wr_address <= 24'h000000;
            wr_data <= 16'h0000;
            cmd_busy <= 1'b0;
            cmd_done <= 1'b0;
        end else begin
            cmd_done <= 1'b0;
            case (state)
                rel_pkg::REL_IDLE: begin
                    if (accept) begin
                        state <= rel_pkg::REL_LOG;
                        word_ix <= 3'h0;
                        base_addr <= cmd_address;
                        cmd_busy <= 1'b1;
                    end
                end
                rel_pkg::REL_LOG: begin
                    if (!wr_valid) begin
                        wr_valid <= 1'b1;
                        wr_address <= base_addr
                            + {20'h00000, word_ix, 1'b0};
                        wr_data <= log_word;
                    end else if (wr_fire) begin
                        wr_valid <= 1'b0;
                        if (word_ix == 3'(rel_pkg::LOG_WORDS - 1)) begin
                            state <= rel_pkg::REL_SSB0;
                        end else begin
                            word_ix <= word_ix + 3'h1;
                        end
                    end
                end
                rel_pkg::REL_SSB0: begin
                    if (!wr_valid) begin
                        wr_valid <= 1'b1;
                        wr_address <= rel_pkg::SSB_OFFSET;
                        wr_data <= rel_pkg::CMD_READ_LOG;
                    end else if (wr_fire) begin
                        wr_valid <= 1'b0;
                        state <= rel_pkg::REL_SSB1;
                    end
                end
                rel_pkg::REL_SSB1: begin
                    if (!wr_valid) begin
                        wr_valid <= 1'b1;
                        wr_address <= rel_pkg::SSB_WORD1_OFFSET;
                        wr_data <= rel_pkg::COMPLETE_DONE;
                    end else if (wr_fire) begin
                        wr_valid <= 1'b0;
                        state <= rel_pkg::REL_IDLE;
                        cmd_busy <= 1'b0;
                        cmd_done <= 1'b1;
                    end
                end
                default: begin
                    state <= rel_pkg::REL_IDLE;
                end
            endcase
        end
    end
endmodule // rel_log

// ===== src/rel_pkg.sv
// Package of constants and types for the ring error log counters.
package rel_pkg;
    // ==================================================================
    // Widths and log layout
    // ==================================================================
    localparam int CNT_W = 8;
    localparam int ADDR_W = 24;
    localparam int LOG_BYTES = 14;
    localparam int LOG_WORDS = 7;
    localparam logic [7:0] CNT_RST = 8'h00;
    localparam logic [7:0] CNT_MAX = 8'hFF;
    localparam logic [7:0] RSVD_BYTE = 8'h00;
    // ==================================================================
    // Command and status block
    // ==================================================================
    localparam logic [15:0] CMD_READ_LOG = 16'h000A;
    localparam logic [15:0] COMPLETE_DONE = 16'h0001;
    localparam logic [23:0] SSB_OFFSET = 24'h000000;
    localparam logic [23:0] SSB_WORD1_OFFSET = 24'h000002;
    // ==================================================================
    // Burst detection in half-bit times
    // ==================================================================
    localparam logic [2:0] BURST_IDLE_HB = 3'h4;
    localparam logic [2:0] BURST_ERR_HB = 3'h5;
    // ==================================================================
    // Token watchdog
    // ==================================================================
    localparam int CLK_MHZ = 100;
    localparam int TOKEN_WINDOW_US = 10000;
    localparam int TOKEN_WINDOW_CYC = TOKEN_WINDOW_US * CLK_MHZ;
    // ==================================================================
    // Counter indices
    // ==================================================================
    localparam int N_CNT = 9;
    localparam int IX_LINE = 0;
    localparam int IX_BURST = 1;
    localparam int IX_ARFC = 2;
    localparam int IX_LOST = 3;
    localparam int IX_CONG = 4;
    localparam int IX_COPY = 5;
    localparam int IX_TOKEN = 6;
    localparam int IX_DMABUS = 7;
    localparam int IX_DMAPAR = 8;

    typedef enum logic [1:0] {
        REL_IDLE,
        REL_LOG,
        REL_SSB0,
        REL_SSB1
    } rel_state_type;
endpackage

// ===== tb/rel_host_model.sv
// Host memory model that takes log and status words with random stalls.
`timescale 1ns/100ps
module rel_host_model (
    input wire logic core_clk,
    input wire logic wr_valid,
    input wire logic [23:0] wr_address,
    input wire logic [15:0] wr_data,
    output logic wr_ready
);
    logic [15:0] mem [logic [23:0]];
    logic [31:0] lfsr = 32'h0000002B;
    initial wr_ready = 1'h0;
    // Stalls are random so the writer must hold each word until taken.
    always @(posedge core_clk) begin
        if (wr_valid && wr_ready) begin
            mem[wr_address] = wr_data;
        end
        lfsr = lfsr ^ (lfsr << 13);
        lfsr = lfsr ^ (lfsr >> 17);
        lfsr = lfsr ^ (lfsr << 5);
        wr_ready <= lfsr[3] | lfsr[9];
    end
endmodule // rel_host_model

// ===== tb/rel_log_checker.sv
// Assertion checker for the ring error log counter ports.
`timescale 1ns/100ps
module rel_log_checker (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic frame_start_delimiter,
    input wire logic half_bit_no_transition,
    input wire logic half_bit_transition,
    input wire logic frame_end_delimiter,
    input wire logic cmd_valid,
    input wire logic [15:0] cmd_code,
    input wire logic [23:0] cmd_address,
    input wire logic wr_ready,
    input wire logic wr_valid,
    input wire logic [23:0] wr_address,
    input wire logic [15:0] wr_data,
    input wire logic cmd_busy,
    input wire logic cmd_done,
    input wire logic tx_force_idle
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Frame window as the block sees it; quiet half-bits only count inside.
    logic in_frm;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            in_frm <= 1'b0;
        end else begin
            in_frm <= frame_start_delimiter
                || (in_frm && !frame_end_delimiter);
        end
    end
    sequence s_accept;
        cmd_valid && cmd_code == rel_pkg::CMD_READ_LOG && !cmd_busy;
    endsequence
    sequence s_quiet4;
        (in_frm && half_bit_no_transition && !half_bit_transition
            && !frame_end_delimiter)[*4];
    endsequence
    property p_start;
        s_accept |-> ##2 wr_valid && wr_address == $past(cmd_address, 2);
    endproperty
    property p_busy3;
        s_accept |=> cmd_busy[*3];
    endproperty
    // The writer may not move a word that the host has not yet taken.
    property p_hold;
        wr_valid && !wr_ready |=> wr_valid && $stable(wr_address)
            && $stable(wr_data);
    endproperty
    property p_refuse;
        cmd_valid && cmd_code != rel_pkg::CMD_READ_LOG && !cmd_busy
            |=> !cmd_busy;
    endproperty
    property p_done;
        cmd_done |-> $past(wr_valid && wr_ready) && !cmd_busy
            && $past(wr_data) == 16'h0001 && !$past(cmd_done)
            && $past(wr_address) == rel_pkg::SSB_WORD1_OFFSET;
    endproperty
    property p_wr_busy;
        wr_valid |-> cmd_busy;
    endproperty
    property p_idle4;
        s_quiet4 |=> tx_force_idle;
    endproperty
    property p_idle_end;
        tx_force_idle && (half_bit_transition || frame_end_delimiter)
            |=> !tx_force_idle;
    endproperty
    a_start: assert property (p_start)
        else $error("log write did not start at the given address");
    a_busy3: assert property (p_busy3)
        else $error("busy did not follow an accepted command");
    a_hold: assert property (p_hold)
        else $error("write word changed before it was taken");
    a_refuse: assert property (p_refuse)
        else $error("unknown command code was taken");
    a_done: assert property (p_done)
        else $error("done without a completion status write");
    a_wr_busy: assert property (p_wr_busy)
        else $error("write request while idle");
    a_idle4: assert property (p_idle4)
        else $error("no idle transmit after four quiet half bits");
    a_idle_end: assert property (p_idle_end)
        else $error("idle transmit held after a transition");
endmodule // rel_log_checker

bind rel_log rel_log_checker i_rel_log_checker (.core_clk, .rst_n,
    .frame_start_delimiter, .half_bit_no_transition, .half_bit_transition,
    .frame_end_delimiter, .cmd_valid, .cmd_code, .cmd_address, .wr_ready,
    .wr_valid, .wr_address, .wr_data, .cmd_busy, .cmd_done, .tx_force_idle);

// ===== tb/tb_rel_log.sv
// Self-checking bench for the ring error log counters.
`timescale 1ns/100ps
module tb_rel_log;
    localparam int TW = 400;
    localparam int LIM = 5;
    logic core_clk = 1'h0;
    logic rst_n = 1'h0;
    logic frame_start_delimiter, frame_end_delimiter, frame_is_token;
    logic frame_repeat_or_copy, error_detected_indicator, code_violation;
    logic token_code_violation, fcs_error, half_bit_no_transition;
    logic half_bit_transition, monitor_pass_bit, own_address_match;
    logic active_monitor_present_frame, standby_monitor_present_frame;
    logic rx_buffer_free, repeat_mode, strip_mode, own_frame_lost;
    logic active_monitor, dma_bus_error, dma_parity_error, dma_error_clear;
    logic cmd_valid, wr_ready, wr_valid, cmd_busy, cmd_done, tx_force_idle;
    logic [2:0] token_priority;
    logic [1:0] address_recognized_copied_bits;
    logic [15:0] cmd_code, wr_data;
    logic [23:0] cmd_address, wr_address;
    logic [7:0] exp_cnt [rel_pkg::N_CNT];
    logic [31:0] seed = 32'h00000029;
    int error_cnt = 0;
    int n_compared = 0;
    int i;

    rel_log #(.TOKEN_WINDOW_CYC(TW), .DMA_ABORT_LIMIT(LIM)) i_rel_log (.*);
    rel_host_model i_rel_host_model (.*);

    initial forever #5 core_clk = ~core_clk;

    task automatic tick;
        @(posedge core_clk);
    endtask
    task automatic clr;
        {frame_start_delimiter, frame_end_delimiter, frame_is_token,
            frame_repeat_or_copy, error_detected_indicator, code_violation,
            token_code_violation, fcs_error, half_bit_no_transition,
            half_bit_transition, monitor_pass_bit, token_priority,
            active_monitor_present_frame, standby_monitor_present_frame,
            address_recognized_copied_bits, own_address_match,
            own_frame_lost, dma_bus_error, dma_parity_error,
            dma_error_clear, cmd_valid} <= '0;
    endtask
    function automatic logic [31:0] rnd;
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic bump(input int k);
        if (exp_cnt[k] != rel_pkg::CNT_MAX) exp_cnt[k]++;
    endtask
    task automatic chk(input string what, input logic [15:0] seen,
            input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic [15:0] word(input int k);
        case (k)
            0: return {exp_cnt[0], 8'h00};
            1: return {exp_cnt[1], exp_cnt[2]};
            3: return {exp_cnt[3], exp_cnt[4]};
            4: return {exp_cnt[5], 8'h00};
            5: return {exp_cnt[6], 8'h00};
            6: return {exp_cnt[7], exp_cnt[8]};
            default: return 16'h0000;
        endcase
    endfunction
    // Frame bits: priority, pass bit, token violation, token, check
    // sequence error, mid-frame violation, indicator, repeated.
    task automatic frame(input logic [9:0] f);
        frame_start_delimiter <= 1'h1;
        tick;
        frame_start_delimiter <= 1'h0;
        code_violation <= f[2];
        tick;
        code_violation <= 1'h0;
        frame_end_delimiter <= 1'h1;
        {token_priority, monitor_pass_bit, token_code_violation,
            frame_is_token, fcs_error} <= f[9:3];
        {error_detected_indicator, frame_repeat_or_copy} <= f[1:0];
        tick;
        clr;
        tick;
        if ((f[0] && !f[1]) || f[2] || f[3] || f[5]) bump(0);
    endtask
    task automatic ev(input logic [6:0] m, input logic [1:0] b);
        {active_monitor_present_frame, standby_monitor_present_frame,
            own_address_match, own_frame_lost, dma_bus_error,
            dma_parity_error, dma_error_clear} <= m;
        address_recognized_copied_bits <= b;
        tick;
        clr;
        tick;
    endtask
    task automatic rd(input logic [23:0] a, input logic lost);
        int k;
        logic [15:0] m [logic [23:0]];
        i_rel_host_model.mem.delete();
        cmd_valid <= 1'h1;
        cmd_code <= rel_pkg::CMD_READ_LOG;
        cmd_address <= a;
        own_frame_lost <= lost;
        tick;
        // A second request while busy must leave no trace.
        cmd_address <= a + 24'h000100;
        own_frame_lost <= 1'h0;
        tick;
        cmd_valid <= 1'h0;
        for (k = 0; k < 400 && cmd_done !== 1'h1; k++) tick;
        if (k == 400) error_cnt++;
        m = i_rel_host_model.mem;
        for (k = 0; k < 7; k++)
            chk("log word", m[a + 24'(2 * k)], word(k));
        chk("word count", 16'(m.num()), 16'h0009);
        chk("status code", m[rel_pkg::SSB_OFFSET], 16'h000A);
        chk("completion", m[rel_pkg::SSB_WORD1_OFFSET], 16'h0001);
        for (k = 0; k < rel_pkg::N_CNT; k++) exp_cnt[k] = 8'h00;
        if (lost) bump(3);
    endtask
    task automatic end_of_test;
        $display("compared %0d errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) tick;
        error_cnt++;
        end_of_test;
    end

    // =================================================================
    // Main sequence
    // =================================================================
    initial begin
        clr;
        {rx_buffer_free, repeat_mode, strip_mode, active_monitor} <= '0;
        cmd_code <= 16'h0000;
        cmd_address <= 24'h000000;
        exp_cnt = '{default: 8'h00};
        repeat (3) tick;
        rst_n <= 1'h1;
        rd(24'h800000, 1'h0);
        for (i = 0; i < 40; i++) frame(10'(rnd() & 32'h0000000F));
        frame(10'h00E);
        rd(24'(rnd() & 32'h007FFFE0) | 24'h800000, 1'h0);
        for (i = 0; i < 260; i++) frame(10'h008);
        frame_start_delimiter <= 1'h1;
        tick;
        frame_start_delimiter <= 1'h0;
        half_bit_no_transition <= 1'h1;
        repeat (5) tick;
        chk("force idle", 16'(tx_force_idle), 16'h0001);
        bump(1);
        half_bit_no_transition <= 1'h0;
        half_bit_transition <= 1'h1;
        tick;
        half_bit_transition <= 1'h0;
        frame_end_delimiter <= 1'h1;
        tick;
        clr;
        tick;
        chk("idle off", 16'(tx_force_idle), 16'h0000);
        for (i = 0; i < 3; i++) ev(7'h20, 2'h0);
        ev(7'h40, 2'h3);
        ev(7'h20, 2'h0);
        bump(2);
        bump(2);
        ev(7'h10, 2'h0);
        repeat_mode <= 1'h1;
        rx_buffer_free <= 1'h1;
        ev(7'h10, 2'h0);
        ev(7'h10, 2'h2);
        bump(5);
        rx_buffer_free <= 1'h0;
        ev(7'h10, 2'h0);
        bump(4);
        ev(7'h08, 2'h0);
        strip_mode <= 1'h1;
        ev(7'h08, 2'h0);
        bump(3);
        for (i = 0; i < 6; i++) ev(7'h06, 2'h0);
        ev(7'h01, 2'h0);
        ev(7'h04, 2'h0);
        for (i = 0; i < LIM; i++) bump(7);
        for (i = 1; i < LIM; i++) bump(8);
        rd(24'h812340, 1'h1);
        cmd_valid <= 1'h1;
        cmd_code <= 16'h0007;
        tick;
        cmd_valid <= 1'h0;
        repeat (2) tick;
        chk("busy", 16'(cmd_busy), 16'h0000);
        frame(10'h000);
        active_monitor <= 1'h1;
        frame(10'h1D0);
        frame(10'h050);
        frame(10'h040);
        frame(10'h030);
        repeat (TW + 50) tick;
        for (i = 0; i < 4; i++) bump(6);
        active_monitor <= 1'h0;
        frame(10'h040);
        rd(24'h900000, 1'h0);
        end_of_test;
    end
endmodule // tb_rel_log
